// File: rtl/split_reload_timer_control.sv
// Control, status, count and reload logic of the split auto-reload timer.
// Assumes a single-cycle SFR port from the core and raw external/oscillator inputs.
`timescale 1ns/10ps
`include "split_reload_timer_map.svh"

module split_reload_timer_control (
  // Clock, reset and enable
  input  wire logic                                  i_core_clk,
  input  wire logic                                  i_reset_n,
  input  wire logic                                  i_clk_en,
  // Register port
  input  wire split_reload_timer_pkg::sfr_request_type i_sfr,
  output logic [7:0]                                 o_sfr_rdata,
  // Per-byte clock selects and interrupt enable from elsewhere
  input  wire logic                                  i_high_byte_clock_select,
  input  wire logic                                  i_low_byte_clock_select,
  input  wire logic                                  i_timer_irq_enable,
  // Clock sources
  input  wire logic                                  i_ext_clock,
  input  wire logic                                  i_low_freq_oscillator,
  input  wire logic                                  i_suspend,
  // Status outputs
  output logic                                       o_timer_irq,
  output logic [15:0]                                o_count,
  output logic [15:0]                                o_reload
);
  import split_reload_timer_pkg::*;

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  control_type ctrl_q, ctrl_d;
  logic [7:0]  cnt_lo_q, cnt_lo_d, cnt_hi_q, cnt_hi_d;
  logic [7:0]  rl_lo_q, rl_lo_d, rl_hi_q, rl_hi_d;
  logic [3:0]  div12_q, div12_d;
  logic [2:0]  ext_div_q, ext_div_d, lfo_div_q, lfo_div_d;
  logic [2:0]  ext_sync_q, ext_sync_d, lfo_sync_q, lfo_sync_d;
  logic [2:0]  osc_sync_q, osc_sync_d;
  logic [7:0]  rdata_q, rdata_d;

  // Combinational helpers.
  logic tick_div12, tick_ext, tick_lfo, alt_tick, tick_lo, tick_hi;
  logic ext_edge, lfo_edge, osc_fall;
  logic en_lo, en_hi, wrap_lo, wrap_hi, wrap_16;
  logic wr_ctrl;

  // ---------------------------------------------------------------------------
  // Source dividers and synchronisers
  // ---------------------------------------------------------------------------
  // The raw sources are sampled through two flops before any edge logic looks at them.
  always_comb begin
    ext_sync_d = {ext_sync_q[1:0], i_ext_clock};
    lfo_sync_d = {lfo_sync_q[1:0], i_low_freq_oscillator};
    osc_sync_d = {osc_sync_q[1:0], i_low_freq_oscillator};
    // Stage 2 vs stage 3 only; stage 1 feeds stage 2 alone.
    ext_edge   = ext_sync_q[1] & ~ext_sync_q[2];
    lfo_edge   = lfo_sync_q[1] & ~lfo_sync_q[2];
    osc_fall   = ~osc_sync_q[1] & osc_sync_q[2];
    tick_div12 = (div12_q == 4'(`SYSTEM_CLOCK_DIVIDE - 1));
    div12_d    = tick_div12 ? 4'h0 : div12_q + 4'h1;
    // Only synchronised edges are counted; the suspend input has no effect on the dividers.
    ext_div_d  = ext_div_q + {2'b00, ext_edge};
    lfo_div_d  = lfo_div_q + {2'b00, lfo_edge};
    tick_ext   = ext_edge & (ext_div_q == 3'(`SOURCE_DIVIDE - 1));
    tick_lfo   = lfo_edge & (lfo_div_q == 3'(`SOURCE_DIVIDE - 1));
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      div12_q    <= 4'h0;
      ext_div_q  <= 3'h0;
      lfo_div_q  <= 3'h0;
      ext_sync_q <= 3'h0;
      lfo_sync_q <= 3'h0;
      osc_sync_q <= 3'h0;
    end else if (i_clk_en) begin
      div12_q    <= div12_d;
      ext_div_q  <= ext_div_d;
      lfo_div_q  <= lfo_div_d;
      ext_sync_q <= ext_sync_d;
      lfo_sync_q <= lfo_sync_d;
      osc_sync_q <= osc_sync_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Clock selection
  // ---------------------------------------------------------------------------
  // Reserved code 10 gives no ticks, so a byte on that source stays still.
  always_comb begin
    unique case (ctrl_q.alt_clock_select)
      ALT_SYSTEM_CLOCK_DIV12: alt_tick = tick_div12;
      ALT_EXT_DIV8:     alt_tick = tick_ext;
      ALT_RESERVED:     alt_tick = 1'b0;
      ALT_LFO_DIV8:     alt_tick = tick_lfo;
    endcase
    tick_lo = i_low_byte_clock_select ? 1'b1 : alt_tick;
    tick_hi = i_high_byte_clock_select ? 1'b1 : alt_tick;
  end

  // ---------------------------------------------------------------------------
  // Count, reload and flags
  // ---------------------------------------------------------------------------
  // In 16-bit mode the low byte's source drives the whole count.
  always_comb begin
    wr_ctrl = i_sfr.write & (i_sfr.addr == `TIMER_CONTROL_OFFSET);
    if (ctrl_q.split_mode_select) begin
      en_lo = tick_lo;
      en_hi = tick_hi & ctrl_q.run_control;
    end else begin
      en_lo = tick_lo & ctrl_q.run_control;
      en_hi = en_lo & (cnt_lo_q == 8'hff);
    end
    wrap_lo = en_lo & (cnt_lo_q == 8'hff);
    wrap_hi = en_hi & (cnt_hi_q == 8'hff);
    wrap_16 = ~ctrl_q.split_mode_select & wrap_hi;

    cnt_lo_d = cnt_lo_q;
    cnt_hi_d = cnt_hi_q;
    rl_lo_d  = rl_lo_q;
    rl_hi_d  = rl_hi_q;
    ctrl_d   = ctrl_q;
    if (wrap_16) begin
      cnt_lo_d = rl_lo_q;
      cnt_hi_d = rl_hi_q;
    end else begin
      if (en_lo) cnt_lo_d = wrap_lo && ctrl_q.split_mode_select ? rl_lo_q : cnt_lo_q + 8'h01;
      if (en_hi) cnt_hi_d = wrap_hi ? rl_hi_q : cnt_hi_q + 8'h01;
    end
    // Software writes land first; hardware sets are applied after so they win.
    if (i_sfr.write) begin
      unique case (i_sfr.addr)
        `TIMER_CONTROL_OFFSET: ctrl_d   = control_type'(i_sfr.wdata);
        `RELOAD_LOW_OFFSET:    rl_lo_d  = i_sfr.wdata;
        `RELOAD_HIGH_OFFSET:   rl_hi_d  = i_sfr.wdata;
        `COUNT_LOW_OFFSET:     cnt_lo_d = i_sfr.wdata;
        `COUNT_HIGH_OFFSET:    cnt_hi_d = i_sfr.wdata;
        default: ;
      endcase
    end
    if (ctrl_q.osc_capture_enable && osc_fall) begin
      rl_lo_d = cnt_lo_q;
      rl_hi_d = cnt_hi_q;
      ctrl_d.high_overflow_flag = 1'b1;
    end
    if (wrap_hi) ctrl_d.high_overflow_flag = 1'b1;
    if (wrap_lo) ctrl_d.low_overflow_flag  = 1'b1;

    // Read data is registered so the core sees it one cycle after the strobe.
    rdata_d = rdata_q;
    if (i_sfr.read) begin
      unique case (i_sfr.addr)
        `TIMER_CONTROL_OFFSET: rdata_d = ctrl_q;
        `RELOAD_LOW_OFFSET:    rdata_d = rl_lo_q;
        `RELOAD_HIGH_OFFSET:   rdata_d = rl_hi_q;
        `COUNT_LOW_OFFSET:     rdata_d = cnt_lo_q;
        `COUNT_HIGH_OFFSET:    rdata_d = cnt_hi_q;
        default:               rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      ctrl_q   <= control_type'(`CTRL_RESET_VALUE);
      cnt_lo_q <= `BYTE_RESET_VALUE;
      cnt_hi_q <= `BYTE_RESET_VALUE;
      rl_lo_q  <= `BYTE_RESET_VALUE;
      rl_hi_q  <= `BYTE_RESET_VALUE;
      rdata_q  <= 8'h00;
    end else if (i_clk_en) begin
      ctrl_q   <= ctrl_d;
      cnt_lo_q <= cnt_lo_d;
      cnt_hi_q <= cnt_hi_d;
      rl_lo_q  <= rl_lo_d;
      rl_hi_q  <= rl_hi_d;
      rdata_q  <= rdata_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  // The request is a level from the flags, so a written high flag, or a low flag with low_byte_irq_enable set, asserts it too.
  assign o_timer_irq = i_timer_irq_enable &
                       (ctrl_q.high_overflow_flag |
                        (ctrl_q.low_byte_irq_enable & ctrl_q.low_overflow_flag));
  assign o_sfr_rdata = rdata_q;
  assign o_count     = {cnt_hi_q, cnt_lo_q};
  assign o_reload    = {rl_hi_q, rl_lo_q};

  // Suspend is accepted but the sources stay resynchronised; direct drive is not modelled.
  logic unused_suspend;
  assign unused_suspend = i_suspend & wr_ctrl;

endmodule

// File: rtl/split_reload_timer_map.svh
// Register offsets, field positions, reset values and timing counts of the timer control block.
// Assumes inclusion by the package and the design module; definitions only.
`ifndef SPLIT_RELOAD_TIMER_MAP_SVH
`define SPLIT_RELOAD_TIMER_MAP_SVH

// ---------------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------------
`define TIMER_CONTROL_OFFSET    8'h91
`define RELOAD_LOW_OFFSET       8'h92
`define RELOAD_HIGH_OFFSET      8'h93
`define COUNT_LOW_OFFSET        8'h94
`define COUNT_HIGH_OFFSET       8'h95

// ---------------------------------------------------------------------------
// Control register fields and reset value
// ---------------------------------------------------------------------------
`define CTRL_HIGH_FLAG_BIT      7
`define CTRL_LOW_FLAG_BIT       6
`define CTRL_LOW_IRQ_EN_BIT     5
`define CTRL_CAPTURE_EN_BIT     4
`define CTRL_SPLIT_BIT          3
`define CTRL_RUN_BIT            2
`define CTRL_ALT_CLK_MSB        1
`define CTRL_ALT_CLK_LSB        0
`define CTRL_RESET_VALUE        8'h00
`define BYTE_RESET_VALUE        8'h00

// ---------------------------------------------------------------------------
// Clock dividers
// ---------------------------------------------------------------------------
`define SYSTEM_CLOCK_DIVIDE           12
`define SOURCE_DIVIDE           8

`endif

// File: rtl/split_reload_timer_pkg.sv
// Types shared by the timer control block and its surroundings.
// Assumes the constant header sits in the same include path.
`include "split_reload_timer_map.svh"

package split_reload_timer_pkg;

  // Alternate clock source encoding.
  typedef enum logic [1:0] {
    ALT_SYSTEM_CLOCK_DIV12 = 2'b00,
    ALT_EXT_DIV8     = 2'b01,
    ALT_RESERVED     = 2'b10,
    ALT_LFO_DIV8     = 2'b11
  } alt_clock_type;

  // Control register layout.
  typedef struct packed {
    logic          high_overflow_flag;
    logic          low_overflow_flag;
    logic          low_byte_irq_enable;
    logic          osc_capture_enable;
    logic          split_mode_select;
    logic          run_control;
    alt_clock_type alt_clock_select;
  } control_type;

  // Special function register access port.
  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_request_type;

endpackage

// File: tb/split_reload_timer_checker.sv
// Port assertions for the split reload timer control block.
// Assumes a bind onto the design module with one clock and a synchronous reset.
`timescale 1ns/10ps
module split_reload_timer_checker
  import split_reload_timer_pkg::*;
(
  // Clock and reset
  input wire logic            i_core_clk,
  input wire logic            i_reset_n,
  input wire logic            i_clk_en,
  // Watched ports
  input wire sfr_request_type i_sfr,
  input wire logic [7:0]      o_sfr_rdata,
  input wire logic            i_timer_irq_enable,
  input wire logic            o_timer_irq,
  input wire logic [15:0]     o_count,
  input wire logic [15:0]     o_reload
);
  // Only strobes seen with the clock enable high are taken by the block.
  wire logic wr_take = i_clk_en & i_sfr.write;
  wire logic rd_take = i_clk_en & i_sfr.read;
  // Shadow of the split bit, so a low byte wrap knows whether it reloads or rolls to zero.
  logic split_q;
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      split_q <= 1'b0;
    end else if (wr_take && i_sfr.addr == 8'h91) begin
      split_q <= i_sfr.wdata[3];
    end
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  irq_gate_a: assert property (
    !i_timer_irq_enable |-> !o_timer_irq) else $error("irq raised while disabled");
  irq_hold_a: assert property (
    $past(o_timer_irq) && $past(i_timer_irq_enable) && i_timer_irq_enable && !$past(wr_take)
    |-> o_timer_irq) else $error("irq dropped without a write");
  flag_write_a: assert property (
    (wr_take && i_sfr.addr == 8'h91 && i_sfr.wdata[7] ##1 i_timer_irq_enable)
    |-> o_timer_irq) else $error("written flag gave no irq");
  low_step_a: assert property (
    !$past(wr_take) && $past(o_count[7:0]) != 8'hff && $changed(o_count[7:0])
    |-> o_count[7:0] == $past(o_count[7:0]) + 8'h01) else $error("low byte bad step");
  low_reload_a: assert property (
    !$past(wr_take) && $past(o_count[7:0]) == 8'hff && $changed(o_count[7:0])
    |-> o_count[7:0] == (($past(split_q) || $past(o_count[15:8]) == 8'hff) ?
                         $past(o_reload[7:0]) : 8'h00)) else $error("low byte not reloaded");
  rdata_hold_a: assert property (
    !$past(rd_take) |-> $stable(o_sfr_rdata)) else $error("read data moved");
  unmapped_zero_a: assert property (
    rd_take && (i_sfr.addr < 8'h91 || i_sfr.addr > 8'h95) |=> o_sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  reload_read_a: assert property (
    rd_take && i_sfr.addr == 8'h92 |=> o_sfr_rdata == $past(o_reload[7:0]))
    else $error("reload read mismatch");
endmodule

bind split_reload_timer_control split_reload_timer_checker split_reload_timer_checker_i (
  .i_core_clk, .i_reset_n, .i_clk_en, .i_sfr, .o_sfr_rdata, .i_timer_irq_enable,
  .o_timer_irq, .o_count, .o_reload);

// File: tb/test_split_reload_timer_control.sv
// Self-checking bench for the split reload timer control block.
// Assumes the checker is bound separately; inputs change on the falling edge.
`timescale 1ns/10ps
module test_split_reload_timer_control;
  import split_reload_timer_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, lsel = 1'b1, ien = 1'b0, ext = 1'b0, low_freq_oscillator = 1'b0;
  sfr_request_type sfr = '0;
  logic [7:0]  rdata, rv;
  logic [15:0] count, reload, c;
  logic        irq;
  int          err_total = 0, tests_run = 0, n;
  always #12.5 clk = ~clk;
  split_reload_timer_control split_reload_timer_control_i (.i_core_clk(clk),
    .i_reset_n(rst_n), .i_clk_en(1'b1), .i_sfr(sfr), .o_sfr_rdata(rdata),
    .i_high_byte_clock_select(1'b1), .i_low_byte_clock_select(lsel),
    .i_timer_irq_enable(ien), .i_ext_clock(ext), .i_low_freq_oscillator(low_freq_oscillator),
    .i_suspend(1'b0), .o_timer_irq(irq), .o_count(count), .o_reload(reload));
  task stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One-cycle strobes, held across exactly one rising edge.
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) sfr = '{1'b1, 1'b0, a, d};
    @(negedge clk) sfr = '0;
  endtask
  task rd(input logic [7:0] a);
    @(negedge clk) sfr = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk) sfr = '0;
    rv = rdata;
  endtask
  task cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  // A hang here is counted and ends the run.
  task wait_irq;
    for (int i = 0; i < 20 && irq !== 1'b1; i++) cyc(1);
    if (irq !== 1'b1) begin
      err_total++;
      stop_test;
    end
  endtask
  task t_reset;
    for (int a = 8'h90; a < 8'h97; a++) begin
      rd(a[7:0]);
      check(rv, 8'h00);
    end
    check(irq, 1'b0);
    $display("reset test done");
  endtask
  task t_wrap16;
    ien = 1'b1;
    wr(8'h92, 8'h34); wr(8'h93, 8'h12); wr(8'h94, 8'hfe); wr(8'h95, 8'hff);
    wr(8'h91, 8'h04);
    wait_irq;
    check(count[15:8], 8'h12);
    rd(8'h91);
    check(rv, 8'hc4);
    cyc(20);
    check(irq, 1'b1);
    wr(8'h91, 8'h00);
    check(irq, 1'b0);
    c = count;
    cyc(5);
    check(count, c);
    $display("wrap test done");
  endtask
  task t_split;
    wr(8'h92, 8'h80); wr(8'h93, 8'h22); wr(8'h95, 8'h40); wr(8'h94, 8'hfd);
    wr(8'h91, 8'h08);
    cyc(6);
    check(count, 16'h4083);
    check(irq, 1'b0);
    wr(8'h91, 8'h68);
    check(irq, 1'b1);
    wr(8'h91, 8'h08); wr(8'h95, 8'hff); wr(8'h91, 8'h0c);
    wait_irq;
    check(count[15:8], 8'h22);
    wr(8'h91, 8'h08);
    // The clear lands on the edge where the low byte wraps; the set must survive.
    wr(8'h94, 8'hfe); wr(8'h91, 8'h08);
    rd(8'h91);
    check(rv, 8'h48);
    $display("split test done");
  endtask
  task t_clocks;
    lsel = 1'b0;
    wr(8'h94, 8'h00); wr(8'h95, 8'h00); wr(8'h91, 8'h04);
    c = count;
    for (n = 0; n < 40 && count === c; n++) cyc(1);
    c = count;
    for (n = 0; n < 40 && count === c; n++) cyc(1);
    check(n[15:0], 16'd12);
    wr(8'h91, 8'h06);
    c = count;
    cyc(30);
    check(count, c);
    wr(8'h91, 8'h00); wr(8'h94, 8'h00); wr(8'h91, 8'h05);
    repeat (16) begin
      ext = 1'b1; cyc(2); ext = 1'b0; cyc(2);
    end
    cyc(4);
    check(count, 16'h0002);
    wr(8'h91, 8'h00); wr(8'h94, 8'h00); wr(8'h91, 8'h07);
    repeat (8) begin
      low_freq_oscillator = 1'b1; cyc(2); low_freq_oscillator = 1'b0; cyc(2);
    end
    cyc(4);
    check(count, 16'h0001);
    $display("clock test done");
  endtask
  task t_capture;
    lsel = 1'b1;
    wr(8'h91, 8'h14);
    cyc(3); low_freq_oscillator = 1'b1; cyc(4); low_freq_oscillator = 1'b0;
    wait_irq;
    check(reload <= count && count - reload < 16'h0010, 1'b1);
    wr(8'h91, 8'h80);
    check(irq, 1'b1);
    ien = 1'b0;
    cyc(1);
    check(irq, 1'b0);
    $display("capture test done");
  endtask
  initial begin
    cyc(20);
    rst_n = 1'b1;
    t_reset; t_wrap16; t_split; t_clocks; t_capture;
    stop_test;
  end
endmodule
